/* File: hw/internal_pwm_enable_pkg.sv */
/*
 Shared constants and types for the colour LED driver: register map, field
 positions, reset values, frame timing and the serial port state type.
 Assumes a 10 MHz core clock.
*/
package internal_pwm_enable_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int FRAME_TIME_NS = 50000;
	localparam int FRAME_CYCLES_DEF = (FRAME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int COUNT_W = 16;
	localparam int SHARE_DENOM = 12;
	localparam logic [2:0] INTENSITY_FULL = 3'h7;

	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_HUE = 8'h01;
	localparam logic [7:0] REG_SCALE = 8'h02;
	localparam logic [7:0] REG_PORT = 8'h06;

	localparam logic [7:0] CONTROL_MASK = 8'hee;
	localparam logic [7:0] HUE_MASK = 8'hff;
	localparam logic [7:0] SCALE_MASK = 8'h3f;
	localparam logic [7:0] PORT_MASK = 8'h0f;
	localparam logic [7:0] CONTROL_RESET = 8'h20;
	localparam logic [7:0] HUE_RESET = 8'h00;
	localparam logic [7:0] SCALE_RESET = 8'h00;
	localparam logic [7:0] PORT_RESET = 8'h00;

	localparam int BIT_PWM_EN = 7;
	localparam int BIT_OUT_EN = 6;
	localparam int BIT_SWITCH = 5;
	localparam int BIT_RED_EN = 3;
	localparam int BIT_GREEN_EN = 2;
	localparam int BIT_BLUE_EN = 1;
	localparam int HUE_HI = 7;
	localparam int HUE_LO = 4;
	localparam int INT_HI = 3;
	localparam int INT_LO = 1;
	localparam int BIT_OVERLAP = 0;
	localparam int RED_SCALE_LO = 4;
	localparam int GREEN_SCALE_LO = 2;
	localparam int BLUE_SCALE_LO = 0;
	localparam int BIT_EXT_PIN_EN = 0;
	localparam int BIT_RED_GATE = 3;
	localparam int BIT_GREEN_GATE = 2;
	localparam int BIT_BLUE_GATE = 1;

	localparam logic [3:0] BYTE_FULL = 4'h8;

	typedef enum logic [3:0] {
		I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_PTR, I2C_PACK, I2C_WDATA, I2C_WACK, I2C_RDATA, I2C_RACK
	} i2c_state_type;
endpackage

/* File: hw/i2c_reg_port.sv */
/*
 Serial register port: an I2C-compatible slave with a register pointer that
 advances after each data byte, read or written.
 Assumes scl and sda are already synchronous to the core clock and that the
 core clock is well above the serial bit rate.
*/
`timescale 1ns/1ps
module i2c_reg_port #(
	parameter logic [6:0] DEV_ADDR = 7'h2c
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic wr_stb_o,
	output logic [7:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	output logic [7:0] rd_addr_o,
	input wire logic [7:0] rd_data_i
);
	import internal_pwm_enable_pkg::*;

	typedef struct packed {
		i2c_state_type st;
		logic [3:0] bits;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic rw;
		logic drive;
		logic scl_q;
		logic sda_q;
		logic wr_stb;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
	} port_state_type;

	port_state_type st, next_st;
	logic rise, fall, start, stop;

	assign rise = scl_i & ~st.scl_q;
	assign fall = ~scl_i & st.scl_q;
	assign start = scl_i & st.scl_q & st.sda_q & ~sda_i;
	assign stop = scl_i & st.scl_q & ~st.sda_q & sda_i;

	always_comb begin
		next_st = st;
		next_st.scl_q = scl_i;
		next_st.sda_q = sda_i;
		next_st.wr_stb = 1'b0;
		if (start) begin
			next_st.st = I2C_ADDR;
			next_st.bits = '0;
			next_st.drive = 1'b0;
		end else if (stop) begin
			next_st.st = I2C_IDLE;
			next_st.drive = 1'b0;
		end else if (rise) begin
			case (st.st)
				I2C_ADDR, I2C_PTR, I2C_WDATA: begin
					next_st.sh = {st.sh[6:0], sda_i};
					next_st.bits = st.bits + 4'h1;
				end
				I2C_RACK: begin
					// A not-acknowledge ends the read burst.
					if (sda_i) begin
						next_st.st = I2C_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (fall) begin
			case (st.st)
				I2C_ADDR: begin
					if (st.bits == BYTE_FULL) begin
						if (st.sh[7:1] == DEV_ADDR) begin
							next_st.st = I2C_AACK;
							next_st.drive = 1'b1;
							next_st.rw = st.sh[0];
						end else begin
							next_st.st = I2C_IDLE;
						end
					end
				end
				I2C_PTR: begin
					if (st.bits == BYTE_FULL) begin
						next_st.st = I2C_PACK;
						next_st.drive = 1'b1;
						next_st.ptr = st.sh;
					end
				end
				I2C_WDATA: begin
					if (st.bits == BYTE_FULL) begin
						next_st.st = I2C_WACK;
						next_st.drive = 1'b1;
						next_st.wr_stb = 1'b1;
						next_st.wr_addr = st.ptr;
						next_st.wr_data = st.sh;
						next_st.ptr = st.ptr + 8'h01;
					end
				end
				I2C_AACK, I2C_RACK: begin
					if (st.st == I2C_AACK && !st.rw) begin
						next_st.st = I2C_PTR;
						next_st.bits = '0;
						next_st.drive = 1'b0;
					end else begin
						next_st.st = I2C_RDATA;
						next_st.sh = rd_data_i;
						next_st.bits = 4'h1;
						next_st.drive = ~rd_data_i[7];
					end
				end
				I2C_PACK, I2C_WACK: begin
					next_st.st = I2C_WDATA;
					next_st.bits = '0;
					next_st.drive = 1'b0;
				end
				I2C_RDATA: begin
					if (st.bits == BYTE_FULL) begin
						next_st.st = I2C_RACK;
						next_st.drive = 1'b0;
						next_st.ptr = st.ptr + 8'h01;
					end else begin
						next_st.sh = {st.sh[6:0], 1'b0};
						next_st.drive = ~st.sh[6];
						next_st.bits = st.bits + 4'h1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st <= '{st: I2C_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// The line is only ever pulled low; a released line floats high.
	assign sda_o = 1'b0;
	assign sda_oe_o = st.drive;
	assign wr_stb_o = st.wr_stb;
	assign wr_addr_o = st.wr_addr;
	assign wr_data_o = st.wr_data;
	assign rd_addr_o = st.ptr;
endmodule

/* File: hw/rgb_led_pwm_driver.sv */
/*
 Colour LED driver core: control registers, 50 us PWM frame, overlapping and
 non-overlapping colour generation, direct on/off and external pulse gating.
 Assumes a 10 MHz clock, synchronous inputs, and an analog output stage that
 takes the on/off level, switch-mode select and current scale per channel.
*/
// Behaviour
// - Intensity code is logarithmic: 0 off, 1 is 1/64, each step doubles to full.
// - Hue shares apply only in non-overlapping mode.
// - Overlapping mode drives enabled channels together, brightness by duty cycle.
// - Non-overlapping splits a 50 us frame into slots; dimming shortens every slot.
// - Outputs enabled without internal PWM follow channel enables directly.
// - Switch select high gives switch mode, low gives current sink; resets to switch.
// - Current scale register holds red 5:4, green 3:2, blue 1:0.
// - Scale codes give quarter, half, three quarters and full current.
// - Pulse pin works only with pin enable and outputs enable both high.
// - Gate select bits pick gated outputs; each still needs its channel enable.
// - External pulse is active high.
// - Without PWM outputs follow the pulse; with PWM the pulse gates the waveform.
// - Enabled ungated outputs ignore the pulse level; without PWM they stay on.
// - Control register 00H: PWM bit 7, enable 6, switch 5, channels 3..1.
// - Register 01H: hue 7:4, intensity 3:1, overlap select bit 0.
// - Overlap select 1 means overlapping, 0 means non-overlapping.
// - Internal PWM frame repeats at 20 kHz from the core clock.
`timescale 1ns/1ps
module rgb_led_pwm_driver #(
	parameter int FRAME_CYCLES = internal_pwm_enable_pkg::FRAME_CYCLES_DEF,
	parameter logic [6:0] DEV_ADDR = 7'h2c
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic ext_pulse_i,
	output logic red_sink_output_o,
	output logic green_sink_output_o,
	output logic blue_sink_output_o,
	output logic switch_mode_o,
	output logic [1:0] red_current_scale_o,
	output logic [1:0] green_current_scale_o,
	output logic [1:0] blue_current_scale_o
);
	import internal_pwm_enable_pkg::*;

	typedef logic [COUNT_W-1:0] count_type;

	typedef struct packed {
		logic [7:0] control;
		logic [7:0] hue;
		logic [7:0] scale;
		logic [7:0] port;
		count_type count;
		logic [2:0] outs;
	} core_state_type;

	core_state_type st, next_st;
	logic wr_stb;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data;

	i2c_reg_port #(.DEV_ADDR(DEV_ADDR)) port_u (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o),
		.wr_stb_o(wr_stb),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data)
	);

	// Shares in twelfths of the frame for red, green and blue.
	function automatic logic [11:0] hue_share(input logic [3:0] code);
		unique case (code)
			4'h0: hue_share = {4'hc, 4'h0, 4'h0};
			4'h1: hue_share = {4'h0, 4'hc, 4'h0};
			4'h2: hue_share = {4'h0, 4'h0, 4'hc};
			4'h3: hue_share = {4'h6, 4'h6, 4'h0};
			4'h4: hue_share = {4'h0, 4'h6, 4'h6};
			4'h5: hue_share = {4'h6, 4'h0, 4'h6};
			4'h6: hue_share = {4'h4, 4'h4, 4'h4};
			4'h7: hue_share = {4'h6, 4'h3, 4'h3};
			4'h8: hue_share = {4'h3, 4'h6, 4'h3};
			4'h9: hue_share = {4'h3, 4'h6, 4'h3};
			4'ha: hue_share = {4'h3, 4'h3, 4'h6};
			4'hb: hue_share = {4'h9, 4'h3, 4'h0};
			4'hc: hue_share = {4'h0, 4'h9, 4'h3};
			4'hd: hue_share = {4'h3, 4'h9, 4'h0};
			4'he: hue_share = {4'h0, 4'h3, 4'h9};
			4'hf: hue_share = {4'h3, 4'h0, 4'h9};
		endcase
	endfunction

	// Integer division drops any remainder, so a frame that is not a multiple of twelve
	// leaves a few dark cycles at its end rather than stretching one slot.
	function automatic count_type slot_len(input logic [3:0] share);
		slot_len = COUNT_W'((FRAME_CYCLES * int'(share)) / SHARE_DENOM);
	endfunction

	// Each intensity step halves the on-time; code zero turns it off.
	function automatic count_type dim(input count_type len, input logic [2:0] code);
		if (code == 3'h0) begin
			dim = '0;
		end else begin
			dim = len >> (INTENSITY_FULL - code);
		end
	endfunction

	logic pwm_en, out_en, ext_active, overlap;
	logic [2:0] intensity, ch_en, gate_sel, pwm_wave, want;
	logic [11:0] share;
	count_type red_len, green_len, blue_len, full_len;

	assign pwm_en = st.control[BIT_PWM_EN];
	assign out_en = st.control[BIT_OUT_EN];
	assign ch_en = {st.control[BIT_RED_EN], st.control[BIT_GREEN_EN], st.control[BIT_BLUE_EN]};
	assign intensity = st.hue[INT_HI:INT_LO];
	assign overlap = st.hue[BIT_OVERLAP];
	assign share = hue_share(st.hue[HUE_HI:HUE_LO]);
	assign ext_active = st.port[BIT_EXT_PIN_EN] & out_en;
	assign gate_sel = {st.port[BIT_RED_GATE], st.port[BIT_GREEN_GATE], st.port[BIT_BLUE_GATE]};
	assign red_len = dim(slot_len(share[11:8]), intensity);
	assign green_len = dim(slot_len(share[7:4]), intensity);
	assign blue_len = dim(slot_len(share[3:0]), intensity);
	assign full_len = dim(COUNT_W'(FRAME_CYCLES), intensity);

	always_comb begin
		if (overlap) begin
			// All channels open at count zero and share one duty ratio.
			pwm_wave = {3{st.count < full_len}};
		end else begin
			// Slots follow each other; the dimmed remainder stays dark.
			pwm_wave[2] = st.count < red_len;
			pwm_wave[1] = st.count >= red_len && st.count < red_len + green_len;
			pwm_wave[0] = st.count >= red_len + green_len && st.count < red_len + green_len + blue_len;
		end
	end

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (ext_active && gate_sel[i]) begin
				want[i] = ext_pulse_i & (pwm_en ? pwm_wave[i] : 1'b1);
			end else begin
				want[i] = pwm_en ? pwm_wave[i] : 1'b1;
			end
			// The enables come last so that a disabled channel stays dark whatever the pulse pin does.
			want[i] = want[i] & out_en & ch_en[i];
		end
	end

	// Unmapped addresses read as zero so that a stray read never returns stale data.
	always_comb begin
		unique case (rd_addr)
			REG_CONTROL: rd_data = st.control;
			REG_HUE: rd_data = st.hue;
			REG_SCALE: rd_data = st.scale;
			REG_PORT: rd_data = st.port;
			default: rd_data = 8'h00;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.outs = want;
		// The frame runs freely so that 500 cycles give 20 kHz.
		if (st.count == COUNT_W'(FRAME_CYCLES - 1)) begin
			next_st.count = '0;
		end else begin
			next_st.count = st.count + 1'b1;
		end
		// Reserved bits are masked on the way in, so they always read back as zero.
		if (wr_stb) begin
			unique case (wr_addr)
				REG_CONTROL: next_st.control = wr_data & CONTROL_MASK;
				REG_HUE: next_st.hue = wr_data & HUE_MASK;
				REG_SCALE: next_st.scale = wr_data & SCALE_MASK;
				REG_PORT: next_st.port = wr_data & PORT_MASK;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st <= '{control: CONTROL_RESET, hue: HUE_RESET, scale: SCALE_RESET, port: PORT_RESET, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign red_sink_output_o = st.outs[2];
	assign green_sink_output_o = st.outs[1];
	assign blue_sink_output_o = st.outs[0];
	assign switch_mode_o = st.control[BIT_SWITCH];
	// The analog sink turns each code into 1/4, 1/2, 3/4 or full current.
	assign red_current_scale_o = st.scale[RED_SCALE_LO+1:RED_SCALE_LO];
	assign green_current_scale_o = st.scale[GREEN_SCALE_LO+1:GREEN_SCALE_LO];
	assign blue_current_scale_o = st.scale[BLUE_SCALE_LO+1:BLUE_SCALE_LO];

	// Checks sample on the core clock and stay quiet while reset is held.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	a_frame_wrap: assert property (
		st.count == COUNT_W'(FRAME_CYCLES - 1) |=> st.count == '0 ##1 st.count == COUNT_W'(1))
		else $error("frame counter did not wrap");
	a_switch_reset: assert property ($fell(rst_i) |-> switch_mode_o)
		else $error("switch mode not selected after reset");
	a_outputs_off: assert property (!out_en |=> !red_sink_output_o && !green_sink_output_o && !blue_sink_output_o)
		else $error("output on while outputs disabled");
	a_direct_on: assert property (
		(out_en && !pwm_en && !ext_active && ch_en[2]) [*2] |-> red_sink_output_o)
		else $error("direct mode output not on");
	a_zero_bright: assert property (
		pwm_en && intensity == 3'h0 |=> !red_sink_output_o && !green_sink_output_o && !blue_sink_output_o)
		else $error("output on at zero intensity");
	a_overlap_start: assert property (
		out_en && pwm_en && overlap && intensity != 3'h0 && !ext_active && ch_en == 3'h7 && st.count == '0
		|=> red_sink_output_o && green_sink_output_o && blue_sink_output_o)
		else $error("overlapping channels did not start together");
	a_half_tail: assert property (
		pwm_en && !overlap && intensity == 3'h6 && st.count >= COUNT_W'(FRAME_CYCLES / 2)
		|=> !red_sink_output_o && !green_sink_output_o && !blue_sink_output_o)
		else $error("output on in dark half of frame");
	a_one_slot: assert property ($past(pwm_en && !overlap) |-> $onehot0(st.outs))
		else $error("slots overlap in non-overlapping mode");
	a_gate_low: assert property (ext_active && gate_sel[2] && !ext_pulse_i |=> !red_sink_output_o)
		else $error("gated output on while pulse low");
	a_ungated_on: assert property (
		ext_active && !gate_sel[0] && ch_en[0] && !pwm_en |=> blue_sink_output_o)
		else $error("ungated output not on");
	a_scale_write: assert property (
		wr_stb && wr_addr == REG_SCALE |=>
		red_current_scale_o == $past(wr_data[RED_SCALE_LO+1:RED_SCALE_LO]) &&
		green_current_scale_o == $past(wr_data[GREEN_SCALE_LO+1:GREEN_SCALE_LO]) &&
		blue_current_scale_o == $past(wr_data[BLUE_SCALE_LO+1:BLUE_SCALE_LO]))
		else $error("current scale not stored");

	// Register and reset checks look one clock after the event, when the stored value stands.
	a_reset_quiet: assert property (
		$fell(rst_i) |-> !red_sink_output_o && !green_sink_output_o && !blue_sink_output_o && !sda_oe_o)
		else $error("output active right after reset");
	a_control_mask: assert property (
		wr_stb && wr_addr == REG_CONTROL |=> st.control == $past(wr_data & CONTROL_MASK))
		else $error("control register not stored as masked");
	a_hue_store: assert property (
		wr_stb && wr_addr == REG_HUE |=> st.hue == $past(wr_data & HUE_MASK))
		else $error("hue register not stored");
	a_port_store: assert property (
		wr_stb && wr_addr == REG_PORT |=> st.port == $past(wr_data & PORT_MASK))
		else $error("port control register not stored");
	a_switch_follow: assert property (
		wr_stb && wr_addr == REG_CONTROL |=> switch_mode_o == $past(wr_data[BIT_SWITCH]))
		else $error("switch select not taken from control register");
	a_frame_bound: assert property (st.count <= COUNT_W'(FRAME_CYCLES - 1))
		else $error("frame counter out of range");

	// Output checks compare with the registers, count and pulse of the cycle before, as outputs are registered.
	a_channel_off: assert property (!ch_en[1] |=> !green_sink_output_o)
		else $error("disabled channel on");
	a_ext_idle: assert property (
		!st.port[BIT_EXT_PIN_EN] && out_en && !pwm_en && ch_en[1] |=> green_sink_output_o)
		else $error("output gated while pulse pin disabled");
	a_ext_follow: assert property (
		ext_active && gate_sel[1] && ch_en[1] && !pwm_en |=> green_sink_output_o == $past(ext_pulse_i))
		else $error("gated output does not follow pulse");
	a_pwm_gated: assert property (
		ext_active && gate_sel[2] && ch_en[2] && pwm_en |=> red_sink_output_o == $past(ext_pulse_i && pwm_wave[2]))
		else $error("pulse does not gate the waveform");
	a_overlap_equal: assert property (
		out_en && pwm_en && overlap && !ext_active && ch_en == 3'h7 |=>
		red_sink_output_o == green_sink_output_o && green_sink_output_o == blue_sink_output_o)
		else $error("hue divides the frame in overlapping mode");
	a_overlap_len: assert property (
		out_en && pwm_en && overlap && !ext_active && ch_en[2] && st.count >= full_len |=> !red_sink_output_o)
		else $error("overlapping output on past its duty");
	a_red_slot: assert property (
		out_en && pwm_en && !overlap && !ext_active && ch_en[2] && st.count < red_len |=> red_sink_output_o)
		else $error("red slot not on");
	a_green_slot: assert property (
		out_en && pwm_en && !overlap && !ext_active && ch_en[1] && st.count >= red_len &&
		st.count < red_len + green_len |=> green_sink_output_o)
		else $error("green slot not on");
	a_blue_slot: assert property (
		out_en && pwm_en && !overlap && !ext_active && ch_en[0] && st.count >= red_len + green_len &&
		st.count < red_len + green_len + blue_len |=> blue_sink_output_o)
		else $error("blue slot not on");

	c_overlap_run: cover property (pwm_en && overlap && red_sink_output_o ##1 !red_sink_output_o);
	c_slot_walk: cover property (pwm_en && !overlap && red_sink_output_o ##[1:500] green_sink_output_o);
	c_flash_pulse: cover property (ext_active && !pwm_en && $rose(red_sink_output_o));
	c_split_blue: cover property (pwm_en && !overlap && $rose(blue_sink_output_o));
	c_gated_pwm: cover property (ext_active && pwm_en && $rose(green_sink_output_o));
endmodule

/* File: testbench/led_load_model.sv */
/*
 LED load model: after an arm pulse it watches the three sink outputs for
 one frame and counts on-cycles per channel, cycles with two or more on,
 and cycles where the channels disagree.
 Assumes the frame length of the driver under test and a shared clock.
*/
`timescale 1ns/1ps
module led_load_model #(
	parameter int FRAME = 48
) (
	input wire logic clk_i,
	input wire logic arm_i,
	input wire logic red_i,
	input wire logic green_i,
	input wire logic blue_i,
	output logic done_o,
	output logic [15:0] red_cnt_o,
	output logic [15:0] green_cnt_o,
	output logic [15:0] blue_cnt_o,
	output logic [15:0] multi_cnt_o,
	output logic [15:0] skew_cnt_o
);
	int left = 0;

	// Any FRAME consecutive samples of a periodic waveform give the same totals, so no frame alignment is needed.
	always @(posedge clk_i) begin
		if (arm_i) begin
			left <= FRAME;
			red_cnt_o <= 16'h0;
			green_cnt_o <= 16'h0;
			blue_cnt_o <= 16'h0;
			multi_cnt_o <= 16'h0;
			skew_cnt_o <= 16'h0;
		end else if (left > 0) begin
			left <= left - 1;
			red_cnt_o <= red_cnt_o + 16'(red_i);
			green_cnt_o <= green_cnt_o + 16'(green_i);
			blue_cnt_o <= blue_cnt_o + 16'(blue_i);
			multi_cnt_o <= multi_cnt_o + 16'((int'(red_i) + int'(green_i) + int'(blue_i)) > 1);
			skew_cnt_o <= skew_cnt_o + 16'(!(red_i == green_i && green_i == blue_i));
		end
	end

	assign done_o = (left == 0);
endmodule

/* File: testbench/tb_rgb_led_pwm_driver.sv */
/*
 Testbench for the colour LED driver: a serial host drives the register
 port, an LED load model measures frame on-times.
 Assumes the driver's register map and a shortened frame.
*/
`timescale 1ns/1ps
module tb_rgb_led_pwm_driver;
	import internal_pwm_enable_pkg::*;
	localparam int FRAME = 192;
	localparam logic [6:0] DEV = 7'h2c;
	localparam logic [11:0] SHARES [16] = '{12'hc00, 12'h0c0, 12'h00c, 12'h660, 12'h066, 12'h606, 12'h444,
		12'h633, 12'h363, 12'h363, 12'h336, 12'h930, 12'h093, 12'h390, 12'h039, 12'h309};
	logic core_clk_i;
	logic rst_i = 1'b1;
	logic scl = 1'b1;
	logic sda_m = 1'b1;
	logic ext_pulse = 1'b0;
	logic arm = 1'b0;
	logic sda_o, sda_oe, red, green, blue, sw_mode, done;
	logic [1:0] r_sc, g_sc, b_sc;
	logic [15:0] r_cnt, g_cnt, b_cnt, multi, skew;
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;
	// The data line has a pull-up; the device only pulls it low.
	wire sda_w = sda_m & ~(sda_oe & ~sda_o);

	rgb_led_pwm_driver #(.FRAME_CYCLES(FRAME), .DEV_ADDR(DEV)) i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .ext_pulse_i(ext_pulse),
		.red_sink_output_o(red), .green_sink_output_o(green), .blue_sink_output_o(blue),
		.switch_mode_o(sw_mode), .red_current_scale_o(r_sc), .green_current_scale_o(g_sc),
		.blue_current_scale_o(b_sc));
	led_load_model #(.FRAME(FRAME)) i_load (.clk_i(core_clk_i), .arm_i(arm), .red_i(red), .green_i(green),
		.blue_i(blue), .done_o(done), .red_cnt_o(r_cnt), .green_cnt_o(g_cnt), .blue_cnt_o(b_cnt),
		.multi_cnt_o(multi), .skew_cnt_o(skew));

	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			fails++;
			summarize();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask

	task automatic bit_io(input logic b, output logic r);
		sda_m = b;
		tick(2);
		scl = 1'b1;
		tick(3);
		r = sda_w;
		scl = 1'b0;
		tick(3);
	endtask

	task automatic start();
		sda_m = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(3);
		sda_m = 1'b0;
		tick(3);
		scl = 1'b0;
		tick(2);
	endtask

	task automatic stop();
		sda_m = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(3);
		sda_m = 1'b1;
		tick(3);
	endtask

	task automatic xbyte(input logic [7:0] d, input logic mack, input logic chk, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(mack, a);
		if (chk)
			check("ack", 16'(a), 16'h0);
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		start();
		xbyte({DEV, 1'b0}, 1'b1, 1'b1, q);
		xbyte(a, 1'b1, 1'b1, q);
		xbyte(d, 1'b1, 1'b1, q);
		stop();
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		start();
		xbyte({DEV, 1'b0}, 1'b1, 1'b1, q);
		xbyte(a, 1'b1, 1'b1, q);
		start();
		xbyte({DEV, 1'b1}, 1'b1, 1'b1, q);
		xbyte(8'hff, 1'b1, 1'b0, q);
		stop();
		check("register", 16'(q), 16'(e));
	endtask

	// A live check compares the pins now; otherwise it compares one measured frame.
	task automatic rgb(input int er, input int eg, input int eb, input logic live);
		int n;
		if (!live) begin
			arm = 1'b1;
			tick(1);
			arm = 1'b0;
			n = 0;
			while (done !== 1'b1 && n < 2 * FRAME) begin
				tick(1);
				n++;
			end
		end
		check("red", live ? 16'(red) : r_cnt, 16'(er));
		check("green", live ? 16'(green) : g_cnt, 16'(eg));
		check("blue", live ? 16'(blue) : b_cnt, 16'(eb));
	endtask

	task automatic t_regs();
		check("switch", 16'(sw_mode), 16'h1);
		rgb(0, 0, 0, 1'b1);
		rd_chk(REG_CONTROL, 8'h20);
		rd_chk(REG_HUE, 8'h00);
		rd_chk(REG_SCALE, 8'h00);
		rd_chk(8'h03, 8'h00);
		reg_wr(REG_CONTROL, 8'hff);
		rd_chk(REG_CONTROL, 8'hee);
		reg_wr(REG_SCALE, 8'hff);
		rd_chk(REG_SCALE, 8'h3f);
		check("scale", 16'({r_sc, g_sc, b_sc}), 16'h3f);
		reg_wr(REG_SCALE, 8'h06);
		check("scale", 16'({r_sc, g_sc, b_sc}), 16'h06);
		reg_wr(REG_HUE, 8'ha5);
		rd_chk(REG_HUE, 8'ha5);
		reg_wr(REG_CONTROL, 8'h00);
		check("switch", 16'(sw_mode), 16'h0);
	endtask

	task automatic t_direct();
		reg_wr(REG_HUE, 8'h00);
		reg_wr(REG_CONTROL, 8'h4a);
		rgb(FRAME, 0, FRAME, 1'b0);
	endtask

	task automatic t_overlap();
		reg_wr(REG_CONTROL, 8'hce);
		for (int i = 0; i < 8; i++) begin
			reg_wr(REG_HUE, {4'h3, 3'(i), 1'b1});
			rgb(i ? FRAME >> (7 - i) : 0, i ? FRAME >> (7 - i) : 0, i ? FRAME >> (7 - i) : 0, 1'b0);
			check("skew", skew, 16'h0);
		end
	endtask

	task automatic t_split();
		logic [11:0] sh;
		for (int h = 0; h < 16; h++) begin
			for (int i = 6; i < 8; i++) begin
				sh = SHARES[h];
				reg_wr(REG_HUE, {4'(h), 3'(i), 1'b0});
				rgb((16 * sh[11:8]) >> (7 - i), (16 * sh[7:4]) >> (7 - i), (16 * sh[3:0]) >> (7 - i), 1'b0);
				check("overlap", multi, 16'h0);
			end
		end
	endtask

	task automatic t_pulse();
		reg_wr(REG_PORT, 8'h0d);
		rd_chk(REG_PORT, 8'h0d);
		reg_wr(REG_CONTROL, 8'h00);
		reg_wr(REG_SCALE, 8'h3f);
		reg_wr(REG_CONTROL, 8'h4e);
		rgb(0, 0, 1, 1'b1);
		ext_pulse = 1'b1;
		tick(3);
		rgb(1, 1, 1, 1'b1);
		ext_pulse = 1'b0;
		reg_wr(REG_PORT, 8'h0c);
		rgb(1, 1, 1, 1'b1);
		reg_wr(REG_PORT, 8'h0d);
		reg_wr(REG_CONTROL, 8'h46);
		rgb(0, 0, 1, 1'b1);
		reg_wr(REG_CONTROL, 8'hce);
		reg_wr(REG_HUE, 8'h0d);
		rgb(0, 0, FRAME / 2, 1'b0);
		ext_pulse = 1'b1;
		tick(2);
		rgb(FRAME / 2, FRAME / 2, FRAME / 2, 1'b0);
	endtask

	initial begin
		tick(6);
		rst_i = 1'b0;
		tick(2);
		t_regs();
		t_direct();
		t_overlap();
		t_split();
		t_pulse();
		summarize();
	end
endmodule
